// ==== core/lcdc_consts.vh ====
// Purpose: Offsets, field positions, reset values and counts of the segment LCD controller.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef LCDC_CONSTS_VH
`define LCDC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LCDC_OFS_MAIN 12'h000
`define LCDC_OFS_POWER 12'h004
`define LCDC_OFS_SUPPLY 12'h008
`define LCDC_OFS_BLINK 12'h00c
`define LCDC_OFS_RVC 12'h010
`define LCDC_OFS_STATUS 12'h014
`define LCDC_OFS_PEN_LO 12'h018
`define LCDC_OFS_PEN_HI 12'h01c
`define LCDC_OFS_BACKPLANE_ENABLE_VECTOR_LO 12'h020
`define LCDC_OFS_BACKPLANE_ENABLE_VECTOR_HI 12'h024
`define LCDC_OFS_WF_BASE 12'h100
`define LCDC_OFS_WF_LAST 12'h1fc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LCDC_MAIN_EN 7
`define LCDC_MAIN_SRC 6
`define LCDC_MAIN_FRAME_CLOCK_PRESCALE_HI 5
`define LCDC_MAIN_FRAME_CLOCK_PRESCALE_LO 3
`define LCDC_MAIN_DUTY_HI 2
`define LCDC_PWR_IEN 7
`define LCDC_PWR_WAI 1
`define LCDC_PWR_STP 0
`define LCDC_SUP_CPEN 7
`define LCDC_SUP_HREF 6
`define LCDC_SUP_PUMP_CLOCK_ADJUST_HI 5
`define LCDC_SUP_PUMP_CLOCK_ADJUST_LO 4
`define LCDC_SUP_BYP 2
`define LCDC_BLK_BLINK 7
`define LCDC_BLK_ALT 6
`define LCDC_BLK_BLANK 5
`define LCDC_BLK_BLINK_MODE 3
`define LCDC_RVC_EN 7
`define LCDC_STAT_FLAG 0

// ----------------------------------------------------------------------
// Reset values, writable masks and encodings
// ----------------------------------------------------------------------
`define LCDC_RST_MAIN 8'h03
`define LCDC_RST_POWER 8'h00
`define LCDC_RST_SUPPLY 8'h00
`define LCDC_RST_BLINK 8'h00
`define LCDC_RST_RVC 8'h00
`define LCDC_MASK_POWER 8'h83
`define LCDC_MASK_SUPPLY 8'hf7
`define LCDC_MASK_BLINK 8'hef
`define LCDC_MASK_RVC 8'h8f
`define LCDC_DUTY_QUARTER 3'h3
`define LCDC_DUTY_EIGHTH 3'h7
`define LCDC_SUP_LCD_PIN 2'h2
`define LCDC_SUP_CORE 2'h1
`define LCDC_SUP_EXT 2'h3
`define LCDC_ALT_SHIFT 3'h4

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define LCDC_PHASE_TICKS_BASE 16'h0004

`endif

// ==== core/lcdc_edge_sync.v ====
// Purpose: Brings a foreign clock pin into i_clk and marks each rising edge.
// Assumes: The pin toggles well below half the i_clk rate.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps

module lcdc_edge_sync (
    input wire i_clk,
    input wire i_rst,
    input wire i_pin,
    output reg o_rise
);

    reg meta_r;
    reg sync_r;
    reg last_r;

    always @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            last_r <= sync_r;
            o_rise <= sync_r & ~last_r;
        end
    end

endmodule // lcdc_edge_sync

// ==== core/lcdc_top.v ====
// Purpose: Segment LCD controller setup, phase sequencer and pin drive over APB.
// Assumes: i_wait and i_stop come from core logic on i_clk.
// Notes: Analog bias levels are outside; pins carry the digital active level.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "lcdc_consts.vh"

module lcdc_top #(
    parameter NUM_PINS = 64,
    parameter BLINK_CNT_W = 8
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_external_osc_clock,
    input wire i_alternate_clock,
    input wire i_wait,
    input wire i_stop,
    output reg [NUM_PINS-1:0] o_seg_out,
    output reg [NUM_PINS-1:0] o_seg_oe,
    output reg o_irq,
    output reg o_charge_pump_enable,
    output reg o_pump_tripler,
    output reg [1:0] o_pump_clock_adjust,
    output reg o_buffer_bypass,
    output reg o_supply_lcd_pin,
    output reg o_supply_core,
    output reg o_supply_external,
    output reg o_regulator_enable,
    output reg [3:0] o_regulator_trim
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [7:0] main_r;
    reg [7:0] power_r;
    reg [7:0] supply_r;
    reg [7:0] blink_r;
    reg [7:0] rvc_r;
    reg frame_flag_r;
    reg [NUM_PINS-1:0] pen_r;
    reg [NUM_PINS-1:0] backplane_enable_vector_r;
    reg [7:0] wf_mem [0:NUM_PINS-1];

    wire module_enable = main_r[`LCDC_MAIN_EN];
    wire frame_irq_enable = power_r[`LCDC_PWR_IEN];
    wire wait_disable = power_r[`LCDC_PWR_WAI];
    wire stop_disable = power_r[`LCDC_PWR_STP];
    wire blink_enable = blink_r[`LCDC_BLK_BLINK];
    wire alternate_display = blink_r[`LCDC_BLK_ALT];
    wire blank_display = blink_r[`LCDC_BLK_BLANK];
    wire blink_mode = blink_r[`LCDC_BLK_BLINK_MODE];
    wire [2:0] blink_rate = blink_r[2:0];

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // The first access cycle captures read data; the answer comes one
    // cycle later and a write lands on the edge that completes it.
    wire acc = i_psel & i_penable;
    wire wr_done = acc & o_pready & i_pwrite;
    wire in_wf = (i_paddr >= `LCDC_OFS_WF_BASE) && (i_paddr <= `LCDC_OFS_WF_LAST);
    wire [5:0] wf_idx = i_paddr[7:2];
    wire aligned = (i_paddr[1:0] == 2'h0);
    wire status_w1c = wr_done && (i_paddr == `LCDC_OFS_STATUS) &&
        i_pwdata[`LCDC_STAT_FLAG];
    reg [31:0] rd_nxt;
    reg err_nxt;

    always @* begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (!aligned) begin
            err_nxt = 1'b1;
        end else if (i_paddr == `LCDC_OFS_MAIN) begin
            rd_nxt = {24'h00_0000, main_r};
        end else if (i_paddr == `LCDC_OFS_POWER) begin
            rd_nxt = {24'h00_0000, power_r};
        end else if (i_paddr == `LCDC_OFS_SUPPLY) begin
            rd_nxt = {24'h00_0000, supply_r};
        end else if (i_paddr == `LCDC_OFS_BLINK) begin
            rd_nxt = {24'h00_0000, blink_r};
        end else if (i_paddr == `LCDC_OFS_RVC) begin
            rd_nxt = {24'h00_0000, rvc_r};
        end else if (i_paddr == `LCDC_OFS_STATUS) begin
            rd_nxt = {31'h0000_0000, frame_flag_r};
        end else if (i_paddr == `LCDC_OFS_PEN_LO) begin
            rd_nxt = pen_r[31:0];
        end else if (i_paddr == `LCDC_OFS_PEN_HI) begin
            rd_nxt = pen_r[63:32];
        end else if (i_paddr == `LCDC_OFS_BACKPLANE_ENABLE_VECTOR_LO) begin
            rd_nxt = backplane_enable_vector_r[31:0];
        end else if (i_paddr == `LCDC_OFS_BACKPLANE_ENABLE_VECTOR_HI) begin
            rd_nxt = backplane_enable_vector_r[63:32];
        end else if (in_wf) begin
            rd_nxt = {24'h00_0000, wf_mem[wf_idx]};
        end else begin
            err_nxt = 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= acc & ~o_pready;
            if (acc && !o_pready) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_nxt;
                o_pslverr <= err_nxt;
            end else begin
                o_pslverr <= 1'b0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            main_r <= `LCDC_RST_MAIN;
            power_r <= `LCDC_RST_POWER;
            supply_r <= `LCDC_RST_SUPPLY;
            blink_r <= `LCDC_RST_BLINK;
            rvc_r <= `LCDC_RST_RVC;
            pen_r <= {NUM_PINS{1'b0}};
            backplane_enable_vector_r <= {NUM_PINS{1'b0}};
        end else if (wr_done && aligned) begin
            // Any setting may be written in any order; the display only
            // runs while the enable bit is set, whenever it is written.
            if (i_paddr == `LCDC_OFS_MAIN) begin
                main_r <= i_pwdata[7:0];
            end else if (i_paddr == `LCDC_OFS_POWER) begin
                power_r <= i_pwdata[7:0] & `LCDC_MASK_POWER;
            end else if (i_paddr == `LCDC_OFS_SUPPLY) begin
                supply_r <= i_pwdata[7:0] & `LCDC_MASK_SUPPLY;
            end else if (i_paddr == `LCDC_OFS_BLINK) begin
                blink_r <= i_pwdata[7:0] & `LCDC_MASK_BLINK;
            end else if (i_paddr == `LCDC_OFS_RVC) begin
                rvc_r <= i_pwdata[7:0] & `LCDC_MASK_RVC;
            end else if (i_paddr == `LCDC_OFS_PEN_LO) begin
                pen_r[31:0] <= i_pwdata;
            end else if (i_paddr == `LCDC_OFS_PEN_HI) begin
                pen_r[63:32] <= i_pwdata;
            end else if (i_paddr == `LCDC_OFS_BACKPLANE_ENABLE_VECTOR_LO) begin
                backplane_enable_vector_r[31:0] <= i_pwdata;
            end else if (i_paddr == `LCDC_OFS_BACKPLANE_ENABLE_VECTOR_HI) begin
                backplane_enable_vector_r[63:32] <= i_pwdata;
            end
        end
    end

    // Waveform memory has no reset; software must fill it after reset.
    always @(posedge i_clk) begin
        if (wr_done && aligned && in_wf) begin
            wf_mem[wf_idx] <= i_pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // LCD clock source
    // ------------------------------------------------------------------
    wire osc_rise;
    wire alt_rise;

    lcdc_edge_sync u_osc_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_external_osc_clock),
        .o_rise(osc_rise)
    );

    lcdc_edge_sync u_alt_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_alternate_clock),
        .o_rise(alt_rise)
    );

    wire lcd_tick = main_r[`LCDC_MAIN_SRC] ? alt_rise : osc_rise;

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    // Duty and prescale are shadowed; while enabled they reload only at a
    // frame boundary so that a write never cuts a frame short.
    reg [2:0] duty_act_r;
    reg [2:0] frame_clock_prescale_act_r;
    reg [15:0] tick_cnt_r;
    reg [2:0] phase_r;
    reg [BLINK_CNT_W-1:0] blink_cnt_r;
    reg blink_off_r;
    reg running_r;

    wire [15:0] phase_ticks = `LCDC_PHASE_TICKS_BASE << frame_clock_prescale_act_r;
    wire phase_end = lcd_tick && (tick_cnt_r == phase_ticks - 16'h0001);
    wire frame_end = phase_end && (phase_r == duty_act_r);
    wire [BLINK_CNT_W-1:0] blink_top = ({{(BLINK_CNT_W-1){1'b0}}, 1'b1} << blink_rate)
        - {{(BLINK_CNT_W-1){1'b0}}, 1'b1};

    always @(posedge i_clk) begin
        if (i_rst) begin
            duty_act_r <= `LCDC_DUTY_QUARTER;
            frame_clock_prescale_act_r <= 3'h0;
            tick_cnt_r <= 16'h0000;
            phase_r <= 3'h0;
            running_r <= 1'b0;
            blink_cnt_r <= {BLINK_CNT_W{1'b0}};
            blink_off_r <= 1'b0;
        end else if (!module_enable) begin
            running_r <= 1'b0;
            tick_cnt_r <= 16'h0000;
            phase_r <= 3'h0;
            duty_act_r <= main_r[`LCDC_MAIN_DUTY_HI:0];
            frame_clock_prescale_act_r <= main_r[`LCDC_MAIN_FRAME_CLOCK_PRESCALE_HI:`LCDC_MAIN_FRAME_CLOCK_PRESCALE_LO];
        end else begin
            running_r <= 1'b1;
            if (phase_end) begin
                tick_cnt_r <= 16'h0000;
                if (frame_end) begin
                    phase_r <= 3'h0;
                    duty_act_r <= main_r[`LCDC_MAIN_DUTY_HI:0];
                    frame_clock_prescale_act_r <= main_r[`LCDC_MAIN_FRAME_CLOCK_PRESCALE_HI:`LCDC_MAIN_FRAME_CLOCK_PRESCALE_LO];
                end else begin
                    phase_r <= phase_r + 3'h1;
                end
            end else if (lcd_tick) begin
                tick_cnt_r <= tick_cnt_r + 16'h0001;
            end
            // Blink period counts whole frames.
            if (!blink_enable) begin
                blink_cnt_r <= {BLINK_CNT_W{1'b0}};
                blink_off_r <= 1'b0;
            end else if (frame_end) begin
                if (blink_cnt_r >= blink_top) begin
                    blink_cnt_r <= {BLINK_CNT_W{1'b0}};
                    blink_off_r <= ~blink_off_r;
                end else begin
                    blink_cnt_r <= blink_cnt_r + {{(BLINK_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame flag and interrupt
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            frame_flag_r <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            if (running_r && frame_end) begin
                frame_flag_r <= 1'b1;
            end else if (status_w1c) begin
                frame_flag_r <= 1'b0;
            end
            o_irq <= frame_flag_r & frame_irq_enable;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    wire low_power_off = (i_wait & wait_disable) | (i_stop & stop_disable);
    wire show_alt = (alternate_display | (blink_off_r & blink_mode)) &&
        (duty_act_r <= `LCDC_DUTY_QUARTER);
    wire show_blank = blank_display | (blink_off_r & ~blink_mode);
    wire [2:0] fp_phase = show_alt ? (phase_r + `LCDC_ALT_SHIFT) : phase_r;
    reg [NUM_PINS-1:0] seg_nxt;
    reg [NUM_PINS-1:0] oe_nxt;
    integer i;

    always @* begin
        seg_nxt = {NUM_PINS{1'b0}};
        oe_nxt = {NUM_PINS{1'b0}};
        for (i = 0; i < NUM_PINS; i = i + 1) begin
            oe_nxt[i] = running_r & pen_r[i] & ~low_power_off;
            if (backplane_enable_vector_r[i]) begin
                seg_nxt[i] = wf_mem[i][phase_r];
            end else begin
                seg_nxt[i] = wf_mem[i][fp_phase] & ~show_blank;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_seg_out <= {NUM_PINS{1'b0}};
            o_seg_oe <= {NUM_PINS{1'b0}};
            o_charge_pump_enable <= 1'b0;
            o_pump_tripler <= 1'b0;
            o_pump_clock_adjust <= 2'h0;
            o_buffer_bypass <= 1'b0;
            o_supply_lcd_pin <= 1'b0;
            o_supply_core <= 1'b0;
            o_supply_external <= 1'b0;
            o_regulator_enable <= 1'b0;
            o_regulator_trim <= 4'h0;
        end else begin
            o_seg_out <= seg_nxt & oe_nxt;
            o_seg_oe <= oe_nxt;
            o_charge_pump_enable <= supply_r[`LCDC_SUP_CPEN];
            o_pump_tripler <= supply_r[`LCDC_SUP_HREF];
            o_pump_clock_adjust <= supply_r[`LCDC_SUP_PUMP_CLOCK_ADJUST_HI:`LCDC_SUP_PUMP_CLOCK_ADJUST_LO];
            o_buffer_bypass <= supply_r[`LCDC_SUP_BYP];
            o_supply_lcd_pin <= (supply_r[1:0] == `LCDC_SUP_LCD_PIN);
            o_supply_core <= (supply_r[1:0] == `LCDC_SUP_CORE);
            o_supply_external <= (supply_r[1:0] == `LCDC_SUP_EXT);
            o_regulator_enable <= rvc_r[`LCDC_RVC_EN];
            o_regulator_trim <= rvc_r[3:0];
        end
    end

endmodule // lcdc_top

// ==== test/lcdc_top_asserts.sv ====
// Purpose: Port-level checks of the segment LCD controller.
// Assumes: One APB wait state; synchronous active-high reset.
// Notes: Bound into every lcdc_top instance.
`timescale 1ns/1ps

module lcdc_top_asserts #(
    parameter NUM_PINS = 64,
    parameter BLINK_CNT_W = 8
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire [11:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire [NUM_PINS-1:0] o_seg_out,
    input wire [NUM_PINS-1:0] o_seg_oe,
    input wire o_irq,
    input wire o_charge_pump_enable,
    input wire o_supply_lcd_pin,
    input wire o_supply_core,
    input wire o_supply_external
);
    default clocking cb @(posedge i_clk);
    endclocking

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    rst_pins_a: assert property ($fell(i_rst) |-> o_seg_oe == '0 && !o_irq)
        else $error("pins or irq active after reset");
    rst_power_a: assert property ($fell(i_rst) |-> !o_charge_pump_enable && !o_supply_core)
        else $error("power outputs not cleared by reset");
    one_wait_a: assert property (disable iff (i_rst) i_psel && $rose(i_penable) |=> o_pready)
        else $error("access not answered after one wait state");
    ready_pulse_a: assert property (disable iff (i_rst) o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (disable iff (i_rst) o_pslverr |-> o_pready)
        else $error("error without ready");
    unmapped_err_a: assert property (disable iff (i_rst)
        i_psel && i_penable && o_pready && i_paddr == 12'h028 |-> o_pslverr)
        else $error("unmapped access not refused");
    fp_quiet_a: assert property (disable iff (i_rst) (o_seg_out & ~o_seg_oe) == '0)
        else $error("undriven pin shows a level");
    supply_one_a: assert property (disable iff (i_rst)
        $onehot0({o_supply_lcd_pin, o_supply_core, o_supply_external}))
        else $error("more than one supply source");

    err_c: cover property (o_pslverr);
    irq_c: cover property (o_irq);
    run_c: cover property ($rose(o_seg_oe[0]));
endmodule // lcdc_top_asserts

bind lcdc_top lcdc_top_asserts #(.NUM_PINS(NUM_PINS), .BLINK_CNT_W(BLINK_CNT_W)) u_chk (
    .i_clk, .i_rst, .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr, .o_seg_out,
    .o_seg_oe, .o_irq, .o_charge_pump_enable, .o_supply_lcd_pin, .o_supply_core,
    .o_supply_external
);

// ==== test/lcdc_glass_model.sv ====
// Purpose: Glass panel seen from the pins; reports the live backplane phase.
// Assumes: Backplanes sit on pins 0 to 3, one per phase.
// Notes: Gives 4'hf while no backplane is driven active.
`timescale 1ns/1ps

module lcdc_glass_model (
    input wire [63:0] i_seg_out,
    input wire [63:0] i_seg_oe,
    output reg [3:0] o_phase
);
    always @* begin
        o_phase = 4'hf;
        for (int p = 3; p >= 0; p--) begin
            if (i_seg_out[p] && i_seg_oe[p]) o_phase = p[3:0];
        end
    end
endmodule // lcdc_glass_model

// ==== test/testbench.sv ====
// Purpose: Self-checking bench of the segment LCD controller.
// Assumes: APB master waits for ready; LCD clocks come from a divider.
// Notes: Pins 0-3 are backplanes, pin 4 a frontplane.
`timescale 1ns/1ps
`include "lcdc_consts.vh"

module testbench;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg i_psel = 1'b0;
    reg i_penable = 1'b0;
    reg i_pwrite = 1'b0;
    reg [11:0] i_paddr = 12'h000;
    reg [31:0] i_pwdata = 32'h0;
    reg i_external_osc_clock = 1'b0;
    reg i_alternate_clock = 1'b0;
    reg i_wait = 1'b0;
    reg i_stop = 1'b0;
    wire [31:0] o_prdata;
    wire [63:0] o_seg_out, o_seg_oe;
    wire o_pready, o_pslverr, o_irq, o_charge_pump_enable, o_pump_tripler, o_buffer_bypass;
    wire o_supply_lcd_pin, o_supply_core, o_supply_external, o_regulator_enable;
    wire [1:0] o_pump_clock_adjust;
    wire [3:0] o_regulator_trim, phase;
    logic [31:0] mdl [1:4];
    logic [31:0] mask [1:4] = '{`LCDC_MASK_POWER, `LCDC_MASK_SUPPLY, `LCDC_MASK_BLINK,
                                `LCDC_MASK_RVC};
    logic [31:0] rd;
    logic er;
    logic [3:0] div = 4'h0;
    int error_cnt = 0;
    int checked = 0;
    int i, k, n, seen;

    lcdc_top u_dut (
        .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_external_osc_clock, .i_alternate_clock, .i_wait, .i_stop,
        .o_seg_out, .o_seg_oe, .o_irq, .o_charge_pump_enable, .o_pump_tripler,
        .o_pump_clock_adjust, .o_buffer_bypass, .o_supply_lcd_pin, .o_supply_core,
        .o_supply_external, .o_regulator_enable, .o_regulator_trim
    );
    lcdc_glass_model u_glass (.i_seg_out(o_seg_out), .i_seg_oe(o_seg_oe), .o_phase(phase));

    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        div <= div + 4'h1;
        i_alternate_clock <= div[2];
        i_external_osc_clock <= div[3];
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task cmp_word(input string nm, input [31:0] exp, input [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cmp_pin(input string nm, input exp, input got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input string nm, input [11:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp_word(nm, exp, rd);
    endtask
    task close_out;
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #1500000;
        error_cnt++;
        close_out;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rd = $urandom(32'hd849);
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk("main", `LCDC_OFS_MAIN, `LCDC_RST_MAIN);
        for (i = 1; i < 6; i++) rdchk("reset", 12'(4 * i), 32'h0);
        $display("Test reset done");
        for (k = 0; k < 4; k++) begin
            for (i = 1; i < 5; i++) begin
                mdl[i] = ($urandom & mask[i]) | ((i == 2) ? k : 0);
                if (i == 2) mdl[i][1:0] = k[1:0];
                wr(12'(4 * i), mdl[i]);
                rdchk("ctrl", 12'(4 * i), mdl[i]);
            end
            cmp_pin("pump", mdl[2][7], o_charge_pump_enable);
            cmp_pin("tripler", mdl[2][6], o_pump_tripler);
            cmp_word("pump_clock_adjust", mdl[2][5:4], o_pump_clock_adjust);
            cmp_pin("bypass", mdl[2][2], o_buffer_bypass);
            cmp_pin("sup_pin", k == 2, o_supply_lcd_pin);
            cmp_pin("sup_core", k == 1, o_supply_core);
            cmp_pin("sup_ext", k == 3, o_supply_external);
            cmp_pin("reg_en", mdl[4][7], o_regulator_enable);
            cmp_word("trim", mdl[4][3:0], o_regulator_trim);
        end
        apb(1'b0, 12'h028, 32'h0);
        cmp_pin("slverr", 1'b1, er);
        cmp_word("unmapped", 32'h0, rd);
        $display("Test registers done");
        wr(`LCDC_OFS_POWER, 32'h0);
        wr(`LCDC_OFS_BLINK, 32'h0);
        wr(`LCDC_OFS_PEN_LO, 32'h1f);
        wr(`LCDC_OFS_PEN_HI, 32'h0);
        wr(`LCDC_OFS_BACKPLANE_ENABLE_VECTOR_LO, 32'h0f);
        wr(`LCDC_OFS_BACKPLANE_ENABLE_VECTOR_HI, 32'h0);
        for (i = 0; i < 64; i++) wr(12'(`LCDC_OFS_WF_BASE + 4 * i), (i < 4) ? (1 << i) : 5);
        wr(`LCDC_OFS_MAIN, 32'hc3);
        seen = 0;
        for (i = 0; i < 40; i++) begin
            repeat (9) @(posedge i_clk);
            if (phase < 4) begin
                seen |= 1 << phase;
                cmp_pin("front", phase == 0 || phase == 2, o_seg_out[4]);
            end
            cmp_word("idle_oe", 32'h0, o_seg_oe[36:5]);
        end
        cmp_word("phases", 32'hf, seen);
        cmp_pin("irq_masked", 1'b0, o_irq);
        wr(`LCDC_OFS_POWER, 32'h80);
        n = 0;
        while (o_irq !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        cmp_pin("irq", 1'b1, o_irq);
        rdchk("flag", `LCDC_OFS_STATUS, 32'h1);
        wr(`LCDC_OFS_MAIN, 32'h43);
        wr(`LCDC_OFS_STATUS, 32'h1);
        rdchk("flag_clr", `LCDC_OFS_STATUS, 32'h0);
        cmp_pin("irq_off", 1'b0, o_irq);
        cmp_word("oe_off", 32'h0, o_seg_oe[31:0]);
        $display("Test display done");
        wr(`LCDC_OFS_MAIN, 32'hc3);
        for (k = 0; k < 2; k++) begin
            wr(`LCDC_OFS_POWER, 32'h2 >> k);
            i_wait <= (k == 0);
            i_stop <= (k == 1);
            repeat (4) @(posedge i_clk);
            cmp_word("lp_oe", 32'h0, o_seg_oe[31:0]);
            wr(`LCDC_OFS_POWER, 32'h0);
            repeat (4) @(posedge i_clk);
            cmp_pin("lp_on", 1'b1, o_seg_oe[4]);
        end
        i_wait <= 1'b0;
        i_stop <= 1'b0;
        wr(`LCDC_OFS_BLINK, 32'h20);
        repeat (12) begin
            repeat (13) @(posedge i_clk);
            cmp_pin("blank", 1'b0, o_seg_out[4]);
        end
        $display("Test low power and blank done");
        wr(`LCDC_OFS_BLINK, 32'h40);
        wr(`LCDC_OFS_WF_BASE + 12'h010, 32'h30);
        wr(`LCDC_OFS_MAIN, 32'h83);
        seen = 0;
        for (i = 0; i < 40; i++) begin
            repeat (9) @(posedge i_clk);
            if (phase < 4) begin
                seen |= 1 << phase;
                cmp_pin("alt_front", phase < 2, o_seg_out[4]);
            end
        end
        cmp_word("alt_phases", 32'hf, seen);
        $display("Test alternate done");
        close_out;
    end
endmodule // testbench
